// [cwpv_map.vh]
// constants for the configuration word, protection and verify block
`ifndef CWPV_MAP_VH
`define CWPV_MAP_VH
// command codes on the command port
`define CWPV_CMD_NONE      3'h0
`define CWPV_CMD_READ      3'h1
`define CWPV_CMD_BLANK     3'h2
`define CWPV_CMD_ROW       3'h3
`define CWPV_CMD_WORD      3'h4
`define CWPV_CMD_ERASE     3'h5
// configuration word selectors for word program
`define CWPV_SEL_PRIMARY   1'b0
`define CWPV_SEL_SECONDARY 1'b1
// primary configuration word field positions
`define CWPV_P_WDT_FORCE   7
`define CWPV_P_DBG_CHAN    8
`define CWPV_P_BG_DEBUG    11
`define CWPV_P_WRP_N       12
`define CWPV_P_RDP_N       13
// secondary configuration word field positions
`define CWPV_S_TWI_MAP     2
`define CWPV_S_CKSM_LO     6
`define CWPV_S_CKSM_HI     7
`define CWPV_S_OSC_LO      8
`define CWPV_S_OSC_HI      10
// reset, erased and protected values and array sizes
`define CWPV_CW_ERASED     16'hFFFF
`define CWPV_ROW_WORDS     8'h40
`define CWPV_MEM_WORDS     12'h400
`define CWPV_ADDR_W        10
`define CWPV_WORD_ERASED   24'hFFFFFF
`define CWPV_WORD_PROTECT  24'h000000
`endif

// [cwpv_core.v]
// configuration word decode, code protection and code memory access logic
// Operation
// RULE1 - erased code memory reads all ones
// RULE2 - programmer skips id, config, unimplemented on blank; the blank query here walks all 1024 words
// RULE3 - blank query answers blank or not blank
// RULE4 - row program writes one row at address
// RULE5 - programmer advances row address by 80h; the programmer model advances it by CWPV_ROW_WORDS, 40h
// RULE6 - programmer fetches identifier via execute, shift-out; the programmer model holds app_id at a constant instead
// RULE7 - identifier BBh means executive resident
// RULE8 - programmer verifies bytewise, config with code
// RULE9 - programmer verifies before read protect reset
// RULE10 - pin map bit selects default or alternate
// RULE11 - debug bit selects user or debug reset
// RULE12 - clock switch monitor field decoded
// RULE13 - oscillator source field selects reset clock
// RULE14 - watchdog force bit overrides software enable
// RULE15 - debug channel bit selects pin pair
// RULE16 - write protect low fails code programming
// RULE17 - read protect low reads zero
// RULE18 - erase sets both protection bits
// RULE19 - only bulk erase releases protection bits
// RULE20 - programmer writes config bytewise, ones reserved
// RULE21 - programmer keeps protection off until verified
// RULE22 - executive fails programming under read protect
`timescale 1ns/1ps
`default_nettype none
`include "cwpv_map.vh"
module cwpv_core (
   // clock, reset, enable
   input  wire        clk_sys_in,
   input  wire        rst_b_in,
   input  wire        clk_en_in,
   // command port
   input  wire        cmd_valid_in,
   input  wire [2:0]  cmd_code_in,
   input  wire [9:0]  cmd_addr_in,
   input  wire [23:0] cmd_wdata_in,
   input  wire        cmd_cw_sel_in,
   input  wire        cmd_byte_hi_in,
   input  wire        serial_prog_mode_in,
   input  wire        soft_watchdog_enable_in,
   // command answer
   output reg         done_out,
   output reg         fail_out,
   output reg         blank_out,
   output reg  [23:0] rdata_out,
   output reg         busy_out,
   // configuration words and decodes
   output reg  [15:0] config_word_primary_out,
   output reg  [15:0] config_word_secondary_out,
   output reg         twowire_pin_map_select_out,
   output reg         reset_in_debug_out,
   output reg         clock_switch_en_out,
   output reg         fail_safe_monitor_en_out,
   output reg  [2:0]  initial_osc_source_out,
   output reg         osc_source_reserved_out,
   output reg         watchdog_run_out,
   output reg         debug_channel_select_out
);
   // memory contents, one valid bit per word so unwritten reads ones
   reg [23:0] mem [0:1023];
   reg [1023:0] written;
   // configuration words
   reg [15:0] config_word_primary;
   reg [15:0] config_word_secondary;
   // sequencer state
   localparam ST_IDLE  = 2'b00;
   localparam ST_ROW   = 2'b01;
   localparam ST_BLANK = 2'b10;
   reg [1:0]  state;
   reg [9:0]  ptr;
   reg [6:0]  cnt;
   reg        seen_prog;
   reg [23:0] row_data;

   // read value of a word after protection and erase state
   function [23:0] read_word;
      input        rdp_n;
      input        wr;
      input [23:0] val;
      begin
         // RULE17 read protect zero
         if (!rdp_n)
            read_word = `CWPV_WORD_PROTECT;
         // RULE1 erased reads ones
         else if (!wr)
            read_word = `CWPV_WORD_ERASED;
         else
            read_word = val;
      end
   endfunction

   // memory array writes, no reset on data
   always @(posedge clk_sys_in) begin
      if (clk_en_in && state == ST_ROW)
         mem[ptr] <= row_data;
   end

   // main sequencer and configuration storage
   always @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         state                 <= ST_IDLE;
         ptr                   <= 10'h000;
         cnt                   <= 7'h00;
         seen_prog             <= 1'b0;
         row_data              <= 24'h000000;
         written               <= {1024{1'b0}};
         config_word_primary   <= `CWPV_CW_ERASED;
         config_word_secondary <= `CWPV_CW_ERASED;
         done_out              <= 1'b0;
         fail_out              <= 1'b0;
         blank_out             <= 1'b0;
         rdata_out             <= 24'h000000;
         busy_out              <= 1'b0;
      end else if (clk_en_in) begin
         // done and fail answers are one-cycle pulses; blank and read data hold
         done_out <= 1'b0;
         fail_out <= 1'b0;
         case (state)
            ST_IDLE: begin
               if (cmd_valid_in) begin
                  case (cmd_code_in)
                     `CWPV_CMD_READ: begin
                        rdata_out <= read_word(config_word_primary[`CWPV_P_RDP_N],
                                               written[cmd_addr_in], mem[cmd_addr_in]);
                        done_out  <= 1'b1;
                     end
                     `CWPV_CMD_BLANK: begin
                        // RULE3 blank walk start
                        state    <= ST_BLANK;
                        ptr      <= 10'h000;
                        busy_out <= 1'b1;
                     end
                     `CWPV_CMD_ROW: begin
                        // RULE16 write protect fails
                        // RULE22 read protect fails
                        if (!config_word_primary[`CWPV_P_WRP_N] ||
                            !config_word_primary[`CWPV_P_RDP_N]) begin
                           done_out <= 1'b1;
                           fail_out <= 1'b1;
                        end else begin
                           // RULE4 row from command address
                           state    <= ST_ROW;
                           ptr      <= {cmd_addr_in[9:6], 6'h00};
                           cnt      <= 7'h00;
                           row_data <= cmd_wdata_in;
                           busy_out <= 1'b1;
                        end
                     end
                     `CWPV_CMD_WORD: begin
                        // RULE19 bytes may only clear bits
                        if (cmd_cw_sel_in == `CWPV_SEL_PRIMARY) begin
                           if (cmd_byte_hi_in)
                              config_word_primary[15:8] <= config_word_primary[15:8] & cmd_wdata_in[7:0];
                           else
                              config_word_primary[7:0]  <= config_word_primary[7:0] & cmd_wdata_in[7:0];
                        end else begin
                           if (cmd_byte_hi_in)
                              config_word_secondary[15:8] <= config_word_secondary[15:8] & cmd_wdata_in[7:0];
                           else
                              config_word_secondary[7:0]  <= config_word_secondary[7:0] & cmd_wdata_in[7:0];
                        end
                        done_out <= 1'b1;
                     end
                     `CWPV_CMD_ERASE: begin
                        // RULE18 erase releases protection
                        // RULE19 only in serial mode
                        if (serial_prog_mode_in) begin
                           written               <= {1024{1'b0}};
                           config_word_primary   <= `CWPV_CW_ERASED;
                           config_word_secondary <= `CWPV_CW_ERASED;
                        end else begin
                           fail_out <= 1'b1;
                        end
                        done_out <= 1'b1;
                     end
                     default: begin
                        done_out <= 1'b1;
                        fail_out <= 1'b1;
                     end
                  endcase
               end
            end
            ST_ROW: begin
               // one word per cycle; the row data is repeated across the row
               written[ptr] <= 1'b1;
               ptr <= ptr + 10'h001;
               cnt <= cnt + 7'h01;
               if (cnt == 7'h3F) begin
                  state    <= ST_IDLE;
                  busy_out <= 1'b0;
                  done_out <= 1'b1;
               end
            end
            ST_BLANK: begin
               ptr <= ptr + 10'h001;
               if (ptr == 10'h3FF) begin
                  // RULE3 blank or not blank
                  blank_out <= ~(seen_prog | written[ptr]);
                  seen_prog <= 1'b0;
                  state     <= ST_IDLE;
                  busy_out  <= 1'b0;
                  done_out  <= 1'b1;
               end else begin
                  seen_prog <= seen_prog | written[ptr];
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // configuration decodes, registered outputs
   always @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         config_word_primary_out    <= `CWPV_CW_ERASED;
         config_word_secondary_out  <= `CWPV_CW_ERASED;
         twowire_pin_map_select_out <= 1'b1;
         reset_in_debug_out         <= 1'b0;
         clock_switch_en_out        <= 1'b0;
         fail_safe_monitor_en_out   <= 1'b0;
         initial_osc_source_out     <= 3'h7;
         osc_source_reserved_out    <= 1'b0;
         watchdog_run_out           <= 1'b1;
         debug_channel_select_out   <= 1'b1;
      end else if (clk_en_in) begin
         config_word_primary_out    <= config_word_primary;
         config_word_secondary_out  <= config_word_secondary;
         // RULE10 pin map select
         twowire_pin_map_select_out <= config_word_secondary[`CWPV_S_TWI_MAP];
         // RULE11 debug reset mode
         reset_in_debug_out         <= ~config_word_primary[`CWPV_P_BG_DEBUG];
         // RULE12 clock switch decode
         clock_switch_en_out        <= ~config_word_secondary[`CWPV_S_CKSM_HI];
         fail_safe_monitor_en_out   <= ~config_word_secondary[`CWPV_S_CKSM_HI] &
                                       ~config_word_secondary[`CWPV_S_CKSM_LO];
         // RULE13 oscillator source
         initial_osc_source_out     <= config_word_secondary[`CWPV_S_OSC_HI:`CWPV_S_OSC_LO];
         osc_source_reserved_out    <= (config_word_secondary[`CWPV_S_OSC_HI:`CWPV_S_OSC_LO] == 3'h6);
         // RULE14 watchdog force
         watchdog_run_out           <= config_word_primary[`CWPV_P_WDT_FORCE] | soft_watchdog_enable_in;
         // RULE15 debug channel
         debug_channel_select_out   <= config_word_primary[`CWPV_P_DBG_CHAN];
      end
   end
endmodule
`default_nettype wire

// [cwpv_core_checker.sv]
// assertion checker for the configuration word and protection block
`timescale 1ns/1ps
`default_nettype none
`include "cwpv_map.vh"
module cwpv_core_checker (
   input wire logic        clk_sys_in, rst_b_in, clk_en_in, cmd_valid_in, busy_out, done_out, fail_out,
   input wire logic        serial_prog_mode_in, soft_watchdog_enable_in, twowire_pin_map_select_out,
   input wire logic        reset_in_debug_out, clock_switch_en_out, fail_safe_monitor_en_out,
   input wire logic        osc_source_reserved_out, watchdog_run_out, debug_channel_select_out,
   input wire logic [2:0]  cmd_code_in, initial_osc_source_out,
   input wire logic [23:0] rdata_out,
   input wire logic [15:0] config_word_primary_out, config_word_secondary_out
);
   wire logic [15:0] pw = config_word_primary_out;   // primary word
   wire logic [15:0] sw = config_word_secondary_out; // secondary word
   wire logic        tk = cmd_valid_in && !busy_out && clk_en_in; // command taken
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (!rst_b_in);
   a_pin_map_decode: assert property ($stable(sw) |-> twowire_pin_map_select_out == sw[2])
      else $error("pin map decode wrong");
   a_debug_reset_mode: assert property ($stable(pw) |-> reset_in_debug_out == !pw[11])
      else $error("debug reset decode wrong");
   a_clock_mode_decode: assert property ($stable(sw) |-> clock_switch_en_out == !sw[7]
      && fail_safe_monitor_en_out == (sw[7:6] == 2'b00)) else $error("clock mode decode wrong");
   a_osc_source_decode: assert property ($stable(sw) |-> initial_osc_source_out == sw[10:8]
      && osc_source_reserved_out == (sw[10:8] == 3'b110)) else $error("osc source decode wrong");
   // soft enable is registered too, so compare with last cycle's value
   a_watchdog_force_on: assert property ($stable(pw) && $past(clk_en_in) |->
      watchdog_run_out == (pw[7] | $past(soft_watchdog_enable_in))) else $error("watchdog run wrong");
   a_debug_chan_select: assert property ($stable(pw) |-> debug_channel_select_out == pw[8])
      else $error("debug channel decode wrong");
   a_row_one_row: assert property (tk && cmd_code_in == `CWPV_CMD_ROW && pw[13:12] == 2'b11
      |-> ##65 done_out && !fail_out) else $error("row answer late or failed");
   a_write_protect_fail: assert property (tk && cmd_code_in == `CWPV_CMD_ROW && !pw[12]
      |=> done_out && fail_out) else $error("row not refused under write protect");
   a_read_protect_zero: assert property (tk && cmd_code_in == `CWPV_CMD_READ && !pw[13]
      |=> done_out && rdata_out == 24'h000000) else $error("protected read not zero");
   // word changes at the taking edge, its output copy one edge later
   a_erase_sets_protect: assert property (tk && cmd_code_in == `CWPV_CMD_ERASE && serial_prog_mode_in
      |-> ##2 pw[13:12] == 2'b11) else $error("erase left protection on");
   // a rise seen here was taken two edges back
   a_protect_erase_only: assert property ($rose(pw[12]) || $rose(pw[13]) |->
      $past(cmd_valid_in, 2) && $past(cmd_code_in, 2) == `CWPV_CMD_ERASE && $past(serial_prog_mode_in, 2))
      else $error("protection released");
endmodule
bind cwpv_core cwpv_core_checker i_cwpv_core_checker (.*);
`default_nettype wire

// [cwpv_prog.sv]
// programmer model that issues commands to the block
`timescale 1ns/1ps
`default_nettype none
`include "cwpv_map.vh"
module cwpv_prog (
   input  wire logic        clk_in, done_in, fail_in,
   output var  logic        valid_out, sel_out, hi_out,
   output var  logic [2:0]  code_out,
   output var  logic [9:0]  addr_out,
   output var  logic [23:0] wdata_out
);
   logic last_fail = 1'b0; // fail seen with the last done
   // executive counts as resident only on this identifier
   localparam logic [7:0] EXEC_RESIDENT_ID = 8'hBB;
   // identifier held at a constant; no shift-out of the visible register is modelled
   logic [7:0] app_id = EXEC_RESIDENT_ID;
   initial {valid_out, sel_out, hi_out, code_out, addr_out, wdata_out} = '0;
   // valid for one taking edge, then wait for done; released address and data lines show the inverse
   task automatic run(input logic [2:0] c, input logic [9:0] a, input logic [23:0] d, input logic s, h);
      @(posedge clk_in); #2;
      {valid_out, code_out, addr_out, wdata_out, sel_out, hi_out} = {1'b1, c, a, d, s, h};
      @(posedge clk_in); #2;
      {valid_out, code_out, addr_out, wdata_out} = {1'b0, `CWPV_CMD_NONE, ~a, ~d};
      // a hang is caught by the bench's cycle ceiling
      while (done_in !== 1'b1) begin @(posedge clk_in); #2; end
      last_fail = fail_in;
   endtask
   task automatic cfg(input logic s, input logic [15:0] w);
      run(`CWPV_CMD_WORD, 10'h000, {16'hFFFF, w[7:0]}, s, 1'b0);
      run(`CWPV_CMD_WORD, 10'h000, {16'hFFFF, w[15:8]}, s, 1'b1);
   endtask
   task automatic rows(input logic [9:0] a, input int k, input logic [23:0] d);
      for (int i = 0; i < k; i++) run(`CWPV_CMD_ROW, 10'(int'(a) + i * `CWPV_ROW_WORDS), d, 1'b0, 1'b0);
   endtask
endmodule
`default_nettype wire

// [testbench.sv]
// self-checking bench for the configuration word and protection block
`timescale 1ns/1ps
`default_nettype none
`include "cwpv_map.vh"
module testbench;
   logic clk_sys_in = 0, rst_b_in = 0, pm = 1, sw = 0, ce = 1; // clock, reset, serial mode, soft watchdog, enable
   logic v, s, h, done, fail, blank, busy, map, dbg, cs, fs, ores, wdt, chan;
   logic [2:0] c, osc;
   logic [9:0] a;
   logic [23:0] d, rdata;
   logic [15:0] pri, sec;
   int miscompares = 0, num_checks = 0, cycles = 0;
   always #12.5 clk_sys_in = ~clk_sys_in;
   cwpv_core i_cwpv_core (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .clk_en_in(ce), .cmd_valid_in(v),
      .cmd_code_in(c), .cmd_addr_in(a), .cmd_wdata_in(d), .cmd_cw_sel_in(s), .cmd_byte_hi_in(h),
      .serial_prog_mode_in(pm), .soft_watchdog_enable_in(sw), .done_out(done), .fail_out(fail),
      .blank_out(blank), .rdata_out(rdata), .busy_out(busy), .config_word_primary_out(pri),
      .config_word_secondary_out(sec), .twowire_pin_map_select_out(map), .reset_in_debug_out(dbg),
      .clock_switch_en_out(cs), .fail_safe_monitor_en_out(fs), .initial_osc_source_out(osc),
      .osc_source_reserved_out(ores), .watchdog_run_out(wdt), .debug_channel_select_out(chan));
   cwpv_prog i_cwpv_prog (.clk_in(clk_sys_in), .done_in(done), .fail_in(fail), .valid_out(v), .sel_out(s),
      .hi_out(h), .code_out(c), .addr_out(a), .wdata_out(d));
   task automatic check(input string nm, input logic [23:0] seen, exp);
      num_checks++;
      if (seen !== exp) begin miscompares++; $display("wrong value %s expected %h seen %h", nm, exp, seen); end
   endtask
   task automatic tally_and_finish;
      if (miscompares == 0 && num_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // hang guard, far above the few thousand cycles needed
   always @(posedge clk_sys_in) if (++cycles == 20000) begin miscompares++; tally_and_finish; end
   task automatic tick; @(posedge clk_sys_in); #2; endtask
   task automatic rd(input logic [9:0] ad, input logic [23:0] e); // read one word and compare
      i_cwpv_prog.run(`CWPV_CMD_READ, ad, 24'h0, 1'b0, 1'b0);
      check("rdata", {rdata[23:16], rdata[15:8], rdata[7:0]}, e);
   endtask
   task automatic bq(input logic e); // blank query
      i_cwpv_prog.run(`CWPV_CMD_BLANK, 10'h0, 24'h0, 1'b0, 1'b0);
      check("blank", 24'(blank), 24'(e));
   endtask
   task automatic er; i_cwpv_prog.run(`CWPV_CMD_ERASE, 10'h0, 24'h0, 1'b0, 1'b0); tick; endtask
   task automatic flt(input logic e); check("fail", 24'(i_cwpv_prog.last_fail), 24'(e)); endtask
   initial begin
      repeat (12) @(posedge clk_sys_in);
      #2 rst_b_in = 1;
      tick;
      check("primary", 24'(pri), 24'hFFFF);
      check("secondary", 24'(sec), 24'hFFFF);
      check("decodes", 24'({map, dbg, cs, fs, osc, ores, wdt, chan}), 24'h23B);
      rd(10'h005, 24'hFFFFFF);
      bq(1'b1);
      i_cwpv_prog.rows(10'h040, 2, 24'h123456);
      flt(1'b0);
      rd(10'h040, 24'h123456);
      rd(10'h0BF, 24'h123456);
      rd(10'h03F, 24'hFFFFFF);
      rd(10'h0C0, 24'hFFFFFF);
      // busy through a blank walk, and frozen past its length while enable is low
      fork
         bq(1'b0);
         begin
            repeat (5) tick;
            check("busy", 24'(busy), 24'h1);
            ce = 0;
            repeat (1100) tick;
            check("busy", 24'(busy), 24'h1);
            ce = 1;
         end
      join
      check("busy", 24'(busy), 24'h0);
      er;
      bq(1'b1);
      for (int i = 0; i < 8; i++) begin
         er;
         i_cwpv_prog.cfg(`CWPV_SEL_SECONDARY, {5'h1F, 3'(i), 2'(i), 3'h7, i[0], 2'h3});
         tick;
         check("osc", 24'(osc), 24'(i));
         check("osc reserved", 24'(ores), 24'(i == 6));
         check("pin map", 24'(map), 24'(i[0]));
         check("clock mode", 24'({cs, fs}), 24'({!i[1], i[1:0] == 2'b00}));
         er;
         sw = i[0];
         i_cwpv_prog.cfg(`CWPV_SEL_PRIMARY, ~({4'h0, i[0], 2'h0, i[1], i[2], 7'h0}));
         tick;
         check("debug reset", 24'(dbg), 24'(i[0]));
         check("debug channel", 24'(chan), 24'(!i[1]));
         check("watchdog", 24'(wdt), 24'(!i[2] || i[0]));
      end
      er;
      bq(1'b1);
      er;
      i_cwpv_prog.cfg(`CWPV_SEL_PRIMARY, 16'hEFFF);
      i_cwpv_prog.rows(10'h000, 1, 24'h0F0F0F);
      flt(1'b1);
      rd(10'h000, 24'hFFFFFF);
      i_cwpv_prog.cfg(`CWPV_SEL_PRIMARY, 16'hFFFF);
      tick;
      check("primary", 24'(pri), 24'hEFFF);
      pm = 0;
      er;
      flt(1'b1);
      check("primary", 24'(pri), 24'hEFFF);
      pm = 1;
      er;
      check("primary", 24'(pri), 24'hFFFF);
      i_cwpv_prog.rows(10'h000, 1, 24'hABCDEF);
      rd(10'h000, 24'hABCDEF);
      i_cwpv_prog.cfg(`CWPV_SEL_PRIMARY, 16'hDFFF);
      rd(10'h000, 24'h000000);
      i_cwpv_prog.rows(10'h040, 1, 24'h111111);
      flt(1'b1);
      er;
      rd(10'h000, 24'hFFFFFF);
      tally_and_finish;
   end
endmodule
`default_nettype wire
